// file: common/cants_params.svh
`ifndef CANTS_PARAMS_SVH
`define CANTS_PARAMS_SVH
// ==========================================================
// Register map (byte offsets, 32-bit aligned words)
`define CANTS_NBUF          15
`define CANTS_OFS_BUF0      8'h00
`define CANTS_OFS_IEN       8'h40
`define CANTS_OFS_IPND      8'h44
`define CANTS_OFS_ICLR      8'h48
`define CANTS_OFS_EDIAG     8'h4c
`define CANTS_OFS_TXCUR     8'h50
// ==========================================================
// Buffer control word field layout
`define CANTS_ST_LSB        0
`define CANTS_ST_MSB        3
`define CANTS_PRI_LSB       4
`define CANTS_PRI_MSB       7
`define CANTS_RTR_BIT       8
// ==========================================================
// Status codes
`define CANTS_ST_RX_IDLE    4'h0
`define CANTS_ST_RX_ARMED   4'h2
`define CANTS_ST_RX_FULL    4'h4
`define CANTS_ST_RX_OVER    4'h6
`define CANTS_ST_TX_IDLE    4'h8
`define CANTS_ST_TX_AWAIT   4'ha
`define CANTS_ST_TX_SINGLE  4'hc
`define CANTS_ST_TX_REMOTE  4'he
// ==========================================================
// Misc
`define CANTS_PRI_NONE      8'hff
`define CANTS_IPND_ERRBIT   15
`endif

// file: common/cants_pkg.sv
`default_nettype none
package cants_pkg;
  // Scheduler phases, one-hot
  typedef enum logic [3:0] {
    CANTS_IDLE  = 4'b0001,
    CANTS_SEND  = 4'b0010,
    CANTS_CRC   = 4'b0100,
    CANTS_WAIT  = 4'b1000
  } cants_phase_t;
endpackage : cants_pkg
`default_nettype wire

// file: rtl/cants_ctrl_mem.sv
`include "cants_params.svh"
`default_nettype none
// ==========================================================
// Buffer control words: one register per buffer, read data
// leaves a register one cycle after the read address.
module cants_ctrl_mem #(
  parameter int NBUF  = `CANTS_NBUF,
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // Write port
  input  wire logic                    wrEn,
  input  wire logic [3:0]              wrIdx,
  input  wire logic [WIDTH-1:0]        wrData,
  // Read port
  input  wire logic [3:0]              rdIdx,
  output var  logic [WIDTH-1:0]        rdData,
  // Flat view for the scheduler
  output var  logic [NBUF*WIDTH-1:0]   allWords
);
  logic [WIDTH-1:0] mem_ff [NBUF];   // Storage words
  genvar g;
  // ==========================================================
  // Storage and flat view
  generate
    for (g = 0; g < NBUF; g++)
    begin : gWord
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          mem_ff[g] <= '0;
        else if (wrEn && wrIdx == 4'(g))
          mem_ff[g] <= wrData;
      end
      assign allWords[g*WIDTH +: WIDTH] = mem_ff[g];
    end
  endgenerate
  // Registered read, out of range reads zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdData <= '0;
    else if (rdIdx < 4'(NBUF))
      rdData <= mem_ff[rdIdx];
    else
      rdData <= '0;
  end
endmodule : cants_ctrl_mem
`default_nettype wire

// file: rtl/cants_pick.sv
`include "cants_params.svh"
`default_nettype none
// ==========================================================
// Combinational lowest-priority-value finder
module cants_pick #(
  parameter int NBUF = `CANTS_NBUF
) (
  // Candidates
  input  wire logic [NBUF-1:0]   want,
  input  wire logic [NBUF*4-1:0] prio,
  // Result
  output var  logic              found,
  output var  logic [3:0]        winner,
  output var  logic [7:0]        winPri
);
  // Strict less-than keeps the lower index on a tie
  always_comb
  begin
    found  = 1'b0;
    winner = 4'h0;
    winPri = `CANTS_PRI_NONE;
    for (int i = 0; i < NBUF; i++)
    begin
      if (want[i] && {prio[i*4 +: 4], 4'(i)} < winPri)
      begin
        found  = 1'b1;
        winner = 4'(i);
        winPri = {prio[i*4 +: 4], 4'(i)};
      end
    end
  end
endmodule : cants_pick
`default_nettype wire

// file: rtl/cants_sched.sv
// Operation
// R1 - Arm sets busy; busy blocks all but upper code (busy is set here only when the buffer is started or preselected)
// R2 - From CRC field, preselect best pending request
// R3 - Software cancels next frame by writing send_idle
// R4 - Higher request displaces scheduled; displaced stays pending
// R5 - Failure or lost arbitration: stop, reselect, resend
// R6 - Writes to busy bit always ignored
// R7 - Queued frames sent back to back
// R8 - Priority is send priority over buffer number
// R9 - Equal priority: lower buffer number wins
// R10 - Software idles buffer before loading it
// R11 - Software loads identifier and data before arming
// R12 - Arming codes raise internal transmit request
// R13 - Matching remote frame triggers automatic send
// R14 - Success: data to idle, remote to armed
// R15 - Code 1110 shows busy, sends, awaits remote
// R16 - Code 1010 only awaits remote frame
// R17 - Buffer events raise the single interrupt line
// R18 - CAN error sets error pending and diagnostics
// R19 - Enable gates; pending read-only; cleared via clear
// R20 - Top status bit marks transmit buffer
// R21 - Failed frame stays busy and retries
// R22 - Clear register: one clears, zero ignored
// R23 - Cancelled next frame triggers fresh selection
`include "cants_params.svh"
`default_nettype none
module cants_sched
  import cants_pkg::*;
#(
  parameter int NBUF = `CANTS_NBUF
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // Register port
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output var  logic [31:0]         regRdata,
  // Protocol engine: frame progress, same clock
  input  wire logic                crcStart,
  input  wire logic                frameStart,
  input  wire logic                txDone,
  input  wire logic                txFail,
  input  wire logic                busIdle,
  input  wire logic                rxStored,
  input  wire logic [3:0]          rxBuf,
  input  wire logic                rxRemote,
  input  wire logic [NBUF-1:0]     remoteHit,
  input  wire logic                canError,
  input  wire logic [7:0]          errBits,
  // Protocol engine: transmit command; interrupt line to software
  output var  logic                txReq,
  output var  logic [3:0]          txBuf,
  output var  logic                irq
);
  import cants_pkg::*;
  localparam int W = 10;            // Busy + rtr + pri + code
  localparam int WD = W - 1;        // Word without busy bit

  // ==========================================================
  // State
  typedef struct packed {
    cants_phase_t      phase;
    logic [NBUF-1:0]   busy;        // Busy indication per buffer
    logic [NBUF-1:0]   ready;       // Internal transmit request
    logic              haveCur;     // A frame is on the wire
    logic [3:0]        cur;
    logic              haveNext;    // A frame is preselected
    logic [3:0]        nxt;
    logic [15:0]       ien;
    logic [15:0]       ipnd;
    logic [7:0]        ediag;
    logic [31:0]       rdata;
    logic              txReq;
    logic [3:0]        txBuf;
    logic              irq;
  } cants_state_t;

  cants_state_t s_ff, nxt_s;

  logic [NBUF*WD-1:0] words;        // Code, pri, rtr per buffer
  logic               memWe;
  logic [3:0]         memIdx;
  logic [WD-1:0]      memWd;
  logic [NBUF*4-1:0]  prios;
  logic [NBUF-1:0]    cand;
  logic               found;
  logic [3:0]         win;
  logic [7:0]         winPri;

  // Decode a buffer index from a byte address
  function automatic logic [3:0] bufIdx(input logic [7:0] a);
    return a[5:2];
  endfunction : bufIdx

  function automatic logic isBufAddr(input logic [7:0] a);
    return a < `CANTS_OFS_IEN && a[1:0] == 2'b00 &&
           a[5:2] < 4'(NBUF);
  endfunction : isBufAddr

  // Status code of buffer i
  function automatic logic [3:0] codeOf(input logic [NBUF*WD-1:0] w,
                                        input int i);
    return w[i*WD + `CANTS_ST_LSB +: 4];
  endfunction : codeOf

  // ==========================================================
  // Status memory
  // Software writes take the memory port over remote-hit updates and
  // over a success update to the same buffer, but lose it to a success
  // update of another buffer; the losing write is dropped, not deferred.
  cants_ctrl_mem #(.NBUF(NBUF), .WIDTH(WD)) uMem (
    .mclk     (mclk),
    .resetn   (resetn),
    .wrEn     (memWe),
    .wrIdx    (memIdx),
    .wrData   (memWd),
    .rdIdx    (bufIdx(regAddr)),
    .rdData   (),
    .allWords (words)
  );

  // ==========================================================
  // Candidate list and priority pick
  generate
    for (genvar g = 0; g < NBUF; g++)
    begin : gCand
      assign prios[g*4 +: 4] = words[g*WD + `CANTS_PRI_LSB +: 4];
      assign cand[g] = s_ff.ready[g] && words[g*WD + `CANTS_ST_MSB]; // R20
    end
  endgenerate

  cants_pick #(.NBUF(NBUF)) uPick ( // R8 R9
    .want   (cand),
    .prio   (prios),
    .found  (found),
    .winner (win),
    .winPri (winPri)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [3:0]  wcode;
    logic [3:0]  old;
    logic        hwDone;
    wcode  = regWdata[`CANTS_ST_MSB:`CANTS_ST_LSB];
    old    = 4'h0;
    hwDone = 1'b0;
    nxt_s  = s_ff;
    memWe  = 1'b0;
    memIdx = 4'h0;
    memWd  = '0;
    // Write-one clears come first so that same-cycle set events win
    if (regWr && regAddr == `CANTS_OFS_ICLR) // R19 R22
      nxt_s.ipnd = s_ff.ipnd & ~regWdata[15:0];
    if (regWr && regAddr == `CANTS_OFS_EDIAG)
      nxt_s.ediag = s_ff.ediag & ~regWdata[7:0];

    // Software write to a buffer control word
    if (regWr && isBufAddr(regAddr))
    begin
      old = codeOf(words, int'(bufIdx(regAddr)));
      memWe  = 1'b1;
      memIdx = bufIdx(regAddr);
      // Busy buffer keeps all but the upper code bits; busy bit
      // itself is never part of the stored word
      if (s_ff.busy[bufIdx(regAddr)]) // R1 R6
        memWd = {words[int'(bufIdx(regAddr))*WD + 4 +: 5],
                 wcode[3:1], old[0]};
      else
        memWd = {regWdata[`CANTS_RTR_BIT], regWdata[7:4], wcode[3:1], 1'b0};
      // Arming codes raise the internal request
      if (wcode == `CANTS_ST_TX_SINGLE ||
          wcode == `CANTS_ST_TX_REMOTE) // R12 R15
        // A busy buffer keeps its request as it stands
        nxt_s.ready[bufIdx(regAddr)] |= !s_ff.busy[bufIdx(regAddr)];
      else // R16 R3
        nxt_s.ready[bufIdx(regAddr)] = 1'b0;
      // Cancelled preselected frame drops out and re-runs pick
      if (s_ff.haveNext && s_ff.nxt == bufIdx(regAddr) &&
          wcode == `CANTS_ST_TX_IDLE) // R3 R23
      begin
        nxt_s.haveNext = 1'b0;
        nxt_s.busy[s_ff.nxt] = 1'b0;
      end
      // A failed frame waiting for its retry may be cancelled too
      if (wcode == `CANTS_ST_TX_IDLE &&
          !(s_ff.haveCur && s_ff.cur == bufIdx(regAddr))) // R21
        nxt_s.busy[bufIdx(regAddr)] = 1'b0;
    end

    // Remote frame hits await buffers
    for (int i = 0; i < NBUF; i++)
      if (remoteHit[i] && codeOf(words, i) == `CANTS_ST_TX_AWAIT)
      begin
        nxt_s.ready[i] = 1'b1; // R13
        nxt_s.ipnd[i]  = 1'b1; // R17
      end

    case (s_ff.phase)
      CANTS_IDLE:
      begin
        // Start a frame when something is pending
        if (found && busIdle)
        begin
          nxt_s.haveCur = 1'b1;
          nxt_s.cur     = win;
          nxt_s.busy[win]  = 1'b1; // R1
          nxt_s.ready[win] = 1'b0;
          nxt_s.txReq   = 1'b1;
          nxt_s.txBuf   = win;
          nxt_s.phase   = CANTS_SEND;
        end
      end
      CANTS_SEND:
      begin
        if (crcStart)
          nxt_s.phase = CANTS_CRC; // R2
      end
      CANTS_CRC:
      begin
        // Keep the best pending buffer as next frame
        if (found && !txDone && (!s_ff.haveNext ||
            winPri < {prios[s_ff.nxt*4 +: 4], s_ff.nxt}))
        begin
          if (s_ff.haveNext) // R4
          begin
            nxt_s.busy[s_ff.nxt]  = 1'b0;
            nxt_s.ready[s_ff.nxt] = 1'b1;
          end
          nxt_s.haveNext   = 1'b1;
          nxt_s.nxt        = win;
          nxt_s.busy[win]  = 1'b1; // R2
          nxt_s.ready[win] = 1'b0;
        end
        if (txDone)
        begin
          hwDone = 1'b1;
          nxt_s.busy[s_ff.cur] = 1'b0;
          nxt_s.ipnd[s_ff.cur] = 1'b1; // R17
          if (s_ff.haveNext) // R7
          begin
            nxt_s.cur      = s_ff.nxt;
            nxt_s.txBuf    = s_ff.nxt;
            nxt_s.haveNext = 1'b0;
            nxt_s.phase    = CANTS_SEND;
          end
          else
          begin
            nxt_s.haveCur = 1'b0;
            nxt_s.txReq   = 1'b0;
            nxt_s.phase   = CANTS_IDLE;
          end
        end
      end
      CANTS_WAIT:
      begin
        // Wait out the reception or error frame, then reselect
        if (busIdle) // R5
          nxt_s.phase = CANTS_IDLE;
      end
      default:
        nxt_s.phase = CANTS_IDLE;
    endcase

    // Failure: frame stays pending, preselection is undone
    if (txFail && s_ff.haveCur) // R5 R21
    begin
      nxt_s.ready[s_ff.cur] = 1'b1;
      if (s_ff.haveNext)
      begin
        nxt_s.busy[s_ff.nxt]  = 1'b0;
        nxt_s.ready[s_ff.nxt] = 1'b1;
      end
      nxt_s.haveCur  = 1'b0;
      nxt_s.haveNext = 1'b0;
      nxt_s.txReq    = 1'b0;
      nxt_s.phase    = CANTS_WAIT;
    end

    // Success moves the finished buffer to its follow-on code
    if (hwDone && !(memWe && memIdx == s_ff.cur)) // R14 R15
    begin
      old    = codeOf(words, int'(s_ff.cur));
      memWe  = 1'b1;
      memIdx = s_ff.cur;
      memWd  = words[int'(s_ff.cur)*WD +: WD];
      if (old == `CANTS_ST_TX_REMOTE)
        memWd[3:0] = `CANTS_ST_TX_AWAIT;
      else if (memWd[`CANTS_RTR_BIT])
        memWd[3:0] = `CANTS_ST_RX_ARMED;
      else
        memWd[3:0] = `CANTS_ST_TX_IDLE;
    end
    else if (!memWe)
    begin
      // Remote triggered buffer shows send_then_await_remote
      for (int i = NBUF - 1; i >= 0; i--)
        if (remoteHit[i] && codeOf(words, i) == `CANTS_ST_TX_AWAIT)
        begin
          memWe  = 1'b1;
          memIdx = 4'(i);
          memWd  = words[i*WD +: WD];
          memWd[3:0] = `CANTS_ST_TX_REMOTE;
        end
    end

    // Received data frame stored into an armed buffer
    if (rxStored && !rxRemote && rxBuf < 4'(NBUF))
      nxt_s.ipnd[rxBuf] = 1'b1; // R17

    // CAN error
    if (canError) // R18
    begin
      nxt_s.ipnd[`CANTS_IPND_ERRBIT] = 1'b1;
      nxt_s.ediag = nxt_s.ediag | errBits;
    end

    if (regWr && regAddr == `CANTS_OFS_IEN)
      nxt_s.ien = regWdata[15:0];

    // Registered read data
    nxt_s.rdata = 32'h0;
    if (regRd)
    begin
        case (regAddr)
          `CANTS_OFS_IEN:   nxt_s.rdata = {16'h0, s_ff.ien};
          `CANTS_OFS_IPND:  nxt_s.rdata = {16'h0, s_ff.ipnd};
          `CANTS_OFS_EDIAG: nxt_s.rdata = {24'h0, s_ff.ediag};
          `CANTS_OFS_TXCUR: nxt_s.rdata = {22'h0, s_ff.haveNext,
                               s_ff.nxt, s_ff.haveCur, s_ff.cur};
          default:          nxt_s.rdata = 32'h0;
        endcase
      if (isBufAddr(regAddr))
        // Busy shadows ST[0] and the bit above the priority
        nxt_s.rdata = {23'h0,
          words[int'(bufIdx(regAddr))*WD +: WD] |
          {s_ff.busy[bufIdx(regAddr)], 7'h0,
           s_ff.busy[bufIdx(regAddr)]}};
    end

    nxt_s.irq = |(nxt_s.ipnd & nxt_s.ien); // R19
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff       <= '0;
      s_ff.phase <= CANTS_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  assign regRdata = s_ff.rdata;
  assign txReq = s_ff.txReq;
  assign txBuf = s_ff.txBuf;
  assign irq   = s_ff.irq;

  // ==========================================================
  // Checks
  busyBlocks_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWr && isBufAddr(regAddr) && s_ff.busy[bufIdx(regAddr)]
    |=> words[int'($past(bufIdx(regAddr)))*WD + 4 +: 5] ==
        $past(words[int'(bufIdx(regAddr))*WD + 4 +: 5])) // R1
    else $error("busy buffer content changed");
  armSets_a: assert property (@(posedge mclk) disable iff (!resetn)
    regWr && isBufAddr(regAddr) &&
    regWdata[3:0] == `CANTS_ST_TX_SINGLE && !remoteHit[bufIdx(regAddr)] &&
    !s_ff.busy[bufIdx(regAddr)]
    |=> s_ff.ready[$past(bufIdx(regAddr))]) // R12
    else $error("arming did not raise request");
  noDoubleNext_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_ff.haveNext && s_ff.haveCur |-> s_ff.nxt != s_ff.cur) // R2
    else $error("next equals current");
  failWait_a: assert property (@(posedge mclk) disable iff (!resetn)
    txFail && s_ff.haveCur |=> s_ff.phase == CANTS_WAIT && !txReq) // R5
    else $error("failure did not stop sending");
  retryKept_a: assert property (@(posedge mclk) disable iff (!resetn)
    txFail && s_ff.haveCur && !regWr
    |=> s_ff.ready[$past(s_ff.cur)]) // R21
    else $error("failed frame lost its request");
  backToBack_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_ff.phase == CANTS_CRC && txDone && s_ff.haveNext && !txFail
    |=> txReq && txBuf == $past(s_ff.nxt)) // R7
    else $error("queued frame not sent back to back");
  irqGate_a: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 irq == |($past(nxt_s.ipnd) & $past(nxt_s.ien))) // R19
    else $error("interrupt not gated by enable");
  errFlag_a: assert property (@(posedge mclk) disable iff (!resetn)
    canError |=> s_ff.ipnd[`CANTS_IPND_ERRBIT]) // R18
    else $error("error flag not set");
endmodule : cants_sched
`default_nettype wire

// file: tb/cants_eng_model.sv
`default_nettype none
// ==========================================================
// Protocol engine stand-in: frame start, CRC point, outcome
module cants_eng_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Transmit command from the scheduler
  input  wire logic       txReq,
  input  wire logic [3:0] txBuf,
  // Bench controls: long frames, fail the next outcome
  input  wire logic       slow,
  input  wire logic       failNext,
  // Frame progress back to the scheduler
  output logic            frameStart,
  output logic            crcStart,
  output logic            txDone,
  output logic            txFail,
  output logic            busIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] log [0:63]; // Buffer of every started frame
  int         startCnt;   // Frames started
  int         doneCnt;    // Frames sent successfully
  int         relCnt;     // Times the bus was given up
  int         cnt;        // Phase length counter
  int         ph;         // 0 idle, 1 frame, 2 crc, 3 gap
  // ==========================================================
  // Frame sequencer; a request still up is taken at once
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {frameStart, crcStart, txDone, txFail} <= 4'h0;
      busIdle  <= 1'b1;
      ph       <= 0;
      cnt      <= 0;
      startCnt <= 0;
      doneCnt  <= 0;
      relCnt   <= 0;
    end
    else
    begin
      {frameStart, crcStart, txDone, txFail} <= 4'h0;
      if (cnt != 0)
        cnt <= cnt - 1;
      case (ph)
        0:
        begin
          // Bus free only while nothing is requested
          busIdle <= !txReq;
          if (txReq)
          begin
            frameStart    <= 1'b1;
            log[startCnt] <= txBuf;
            startCnt      <= startCnt + 1;
            cnt           <= slow ? 40 : 4;
            ph            <= 1;
          end
        end
        1:
          if (cnt == 0)
          begin
            crcStart <= 1'b1;
            cnt      <= slow ? 40 : 4;
            ph       <= 2;
          end
        2:
          if (cnt == 0)
          begin
            // A failure stands for lost arbitration or bus error
            txFail  <= failNext;
            txDone  <= !failNext;
            doneCnt <= doneCnt + (failNext ? 0 : 1);
            cnt     <= failNext ? 12 : 3;
            ph      <= 3;
          end
        default:
          if (cnt == 0)
          begin
            // Dropped request here means the bus was released
            relCnt <= relCnt + (txReq ? 0 : 1);
            ph     <= 0;
          end
      endcase
    end
  end
endmodule : cants_eng_model
`default_nettype wire

// file: tb/cants_sched_tb.sv
`include "cants_params.svh"
`default_nettype none
module cants_sched_tb;
  import cants_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        mclk, resetn, regWr, regRd, irq, txReq;
  logic [7:0]  regAddr, errBits;
  logic [31:0] regWdata, regRdata, d;
  logic        crcStart, frameStart, txDone, txFail, busIdle;
  logic        rxStored, rxRemote, canError, slow, failNext;
  logic [3:0]  rxBuf, txBuf;
  logic [14:0] remoteHit;
  int          error_cnt, n_compared, b, r;
  // ==========================================================
  // Design and engine stand-in
  cants_sched #(.NBUF(15)) uut (.mclk(mclk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .crcStart(crcStart),
    .frameStart(frameStart), .txDone(txDone), .txFail(txFail),
    .busIdle(busIdle), .rxStored(rxStored), .rxBuf(rxBuf),
    .rxRemote(rxRemote), .remoteHit(remoteHit),
    .canError(canError), .errBits(errBits), .txReq(txReq),
    .txBuf(txBuf), .irq(irq));
  cants_eng_model eng (.mclk(mclk), .resetn(resetn), .txReq(txReq),
    .txBuf(txBuf), .slow(slow), .failNext(failNext),
    .frameStart(frameStart), .crcStart(crcStart), .txDone(txDone),
    .txFail(txFail), .busIdle(busIdle));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Verdict and compare
  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // A hang counts as a mismatch and closes the run
  task automatic tmo(input string n);
    error_cnt++;
    $display("CHECK FAILED %s exp event got timeout", n);
    end_sim();
  endtask : tmo
  // ==========================================================
  // Register port: one-cycle strobes, read data one cycle later
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
  task automatic chkReg(input string n, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(n, e, d & m);
  endtask : chkReg
  // Busy may show in the low code bit or the bit above priority
  task automatic chkBusy(input string n, input int k, input logic e);
    rd(8'(4 * k));
    chk(n, {31'h0, e}, {31'h0, d[0] | d[8]});
  endtask : chkBusy
  // ==========================================================
  // Engine-side events and bounded waits
  task automatic rem(input int k);
    @(posedge mclk);
    rxRemote  <= 1'b1;
    remoteHit <= 15'h1 << k;
    @(posedge mclk);
    rxRemote  <= 1'b0;
    remoteHit <= 15'h0;
  endtask : rem
  task automatic waitDone(input int k);
    for (int i = 0; i < 3000 && eng.doneCnt < k; i++)
      @(posedge mclk);
    if (eng.doneCnt < k)
      tmo("frame done");
    repeat (4) @(posedge mclk);
  endtask : waitDone
  // Sel 0 waits for the CRC point, 1 for a failed frame
  task automatic waitEv(input logic sel);
    int i;
    for (i = 0; i < 500; i++)
    begin
      @(posedge mclk);
      #1;
      if (sel ? txFail : crcStart)
        break;
    end
    if (i == 500)
      tmo("engine event");
  endtask : waitEv
  // ==========================================================
  // Main sequence
  initial
  begin
    {resetn, regWr, regRd, rxStored, rxRemote, canError} = 6'h0;
    {regAddr, errBits, rxBuf, remoteHit} = 35'h0;
    regWdata = 32'h0;
    slow = 1'b1;
    failNext = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    chkReg("ien rst", 8'h40, 32'hffffffff, 32'h0);
    chkReg("ipnd rst", 8'h44, 32'hffffffff, 32'h0);
    chkReg("hole", 8'h7c, 32'hffffffff, 32'h0);
    // Single send; locked while busy; interrupt and clear
    wr(8'h40, 32'h1);
    wr(8'h00, 32'h0c);
    chkBusy("busy0", 0, 1'b1);
    wr(8'h00, 32'hfc);
    chkReg("lock0", 8'h00, 32'hf0, 32'h0);
    waitDone(1);
    chkReg("code0", 8'h00, 32'h1ff, 32'h8);
    chkReg("ipnd0", 8'h44, 32'h1, 32'h1);
    chk("irq0", 32'h1, {31'h0, irq});
    wr(8'h48, 32'h0);
    chkReg("iclr0", 8'h44, 32'h1, 32'h1);
    wr(8'h48, 32'h1);
    chkReg("iclr1", 8'h44, 32'h1, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h9);
    chkReg("busy wr", 8'h00, 32'h1ff, 32'h8);
    // Queue of four behind a long frame: order and no release
    b = eng.startCnt;
    r = eng.relCnt;
    wr(8'h0c, 32'h0c);
    wr(8'h14, 32'h1c);
    wr(8'h08, 32'h1c);
    wr(8'h04, 32'h2c);
    wr(8'h38, 32'h0c);
    waitDone(6);
    chk("order", 32'h3e251, {12'h0, eng.log[b], eng.log[b+1],
        eng.log[b+2], eng.log[b+3], eng.log[b+4]});
    chk("back2back", 32'(r + 1), 32'(eng.relCnt));
    // Displace the scheduled frame, then cancel the newcomer
    b = eng.startCnt;
    wr(8'h00, 32'h0c);
    wr(8'h18, 32'h3c);
    waitEv(1'b0);
    @(posedge mclk);
    chkBusy("sched6", 6, 1'b1);
    wr(8'h10, 32'h1c);
    chkBusy("displ6", 6, 1'b0);
    chkReg("pend6", 8'h18, 32'he, 32'hc);
    wr(8'h10, 32'h18);
    chkReg("cncl4", 8'h10, 32'h1ff, 32'h18);
    waitDone(8);
    chk("resel", 32'h06, {24'h0, eng.log[b], eng.log[b+1]});
    // Failed frame stays busy and is sent again
    slow <= 1'b0;
    failNext <= 1'b1;
    b = eng.startCnt;
    wr(8'h24, 32'h0c);
    waitEv(1'b1);
    failNext <= 1'b0;
    chkBusy("retry9", 9, 1'b1);
    waitDone(9);
    chk("resend", 32'h99, {24'h0, eng.log[b], eng.log[b+1]});
    // Send then await remote; remote frames trigger answers
    wr(8'h40, 32'h400);
    wr(8'h28, 32'h0e);
    chkReg("st1111", 8'h28, 32'hf, 32'hf);
    waitDone(10);
    chkReg("await10", 8'h28, 32'h1ff, 32'ha);
    chkReg("ipnd10", 8'h44, 32'h400, 32'h400);
    chk("irq10", 32'h1, {31'h0, irq});
    wr(8'h48, 32'h400);
    rem(10);
    waitDone(11);
    chkReg("ans10", 8'h28, 32'h1ff, 32'ha);
    chkReg("ipnd10b", 8'h44, 32'h400, 32'h400);
    wr(8'h2c, 32'h0a);
    repeat (30) @(posedge mclk);
    chk("nosend11", 32'd11, 32'(eng.doneCnt));
    rem(11);
    waitDone(12);
    chk("ans11", 32'hb, {28'h0, eng.log[eng.startCnt-1]});
    // Remote request frame ends in receive armed
    wr(8'h30, 32'h10c);
    waitDone(13);
    chkReg("rtr12", 8'h30, 32'hf, 32'h2);
    // Receive buffer takes a stored frame
    wr(8'h40, 32'h2000);
    wr(8'h34, 32'h02);
    @(posedge mclk);
    rxStored <= 1'b1;
    rxBuf    <= 4'hd;
    @(posedge mclk);
    rxStored <= 1'b0;
    repeat (20) @(posedge mclk);
    chkReg("rx13", 8'h34, 32'hf, 32'h2);
    chkReg("ipnd13", 8'h44, 32'h2000, 32'h2000);
    // Error flag: masked, read-only, then cleared
    wr(8'h48, 32'hffff);
    wr(8'h40, 32'h0);
    @(posedge mclk);
    canError <= 1'b1;
    errBits  <= 8'h05;
    @(posedge mclk);
    canError <= 1'b0;
    chkReg("epnd", 8'h44, 32'h8000, 32'h8000);
    chkReg("ediag", 8'h4c, 32'hff, 32'h05);
    chk("masked", 32'h0, {31'h0, irq});
    wr(8'h40, 32'h8000);
    wr(8'h44, 32'h0);
    chkReg("ipnd ro", 8'h44, 32'h8000, 32'h8000);
    chk("unmask", 32'h1, {31'h0, irq});
    wr(8'h48, 32'h8000);
    chkReg("eclr", 8'h44, 32'h8000, 32'h0);
    end_sim();
  end
endmodule : cants_sched_tb
`default_nettype wire
